// ---- sim/fmd_seq_model.sv ----
// Sequencer stand-in that feeds operands and special instructions
`timescale 1ns/1ps
module fmd_seq_model (
   input  wire logic          clk,
   input  wire logic          busy,
   input  wire logic          done,
   output logic               start,
   output fmd_pkg::fmd_op_t   op,
   output logic               extended_precision_mode,
   output logic [59:0]        floating_accumulator,
   output logic [11:0]        acc_exp,
   output logic [59:0]        opnd_frac,
   output logic [11:0]        opnd_exp,
   output logic               spec_valid,
   output fmd_pkg::fmd_spec_t spec_kind,
   output logic               spec_cond
);
   initial begin
      start = 1'b0;
      op = fmd_pkg::FMD_OP_MUL;
      extended_precision_mode = 1'b0;
      floating_accumulator = 60'h0;
      acc_exp = 12'h000;
      opnd_frac = 60'h0;
      opnd_exp = 12'h000;
      spec_valid = 1'b0;
      spec_kind = fmd_pkg::FMD_SP_EXIT;
      spec_cond = 1'b0;
   end

   task automatic issue(input fmd_pkg::fmd_op_t o, input logic x, input logic [59:0] f,
                        input logic [11:0] e, input logic [59:0] g, input logic [11:0] ge,
                        output logic seen, output logic bz);
      int n;
      // One edge between calls, so no operand line is driven twice in a step
      @(posedge clk);
      #1;
      start = 1'b1;
      op = o;
      extended_precision_mode = x;
      floating_accumulator = f;
      acc_exp = e;
      opnd_frac = g;
      opnd_exp = ge;
      @(posedge clk);
      #1;
      bz = busy;
      // Start kept high one more edge on purpose: must be ignored while busy
      op = fmd_pkg::FMD_OP_FLOAT;
      @(posedge clk);
      #1;
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      seen = done;
      // Break cycle over: operand lines no longer carry the old word
      opnd_frac = ~g;
      opnd_exp = ~ge;
   endtask

   task automatic spec(input fmd_pkg::fmd_spec_t k, input logic c, input logic hold);
      spec_valid = 1'b1;
      spec_kind = k;
      spec_cond = c;
      @(posedge clk);
      #1;
      spec_valid = hold;
   endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the fraction arithmetic datapath
`timescale 1ns/1ps
module tb_top;
   logic               clk, rst_b, start, extended_precision_mode, spec_valid, spec_cond;
   logic               busy, done, fixable, fetch_done, enter_process;
   fmd_pkg::fmd_op_t   op;
   fmd_pkg::fmd_spec_t spec_kind;
   logic [59:0]        floating_accumulator, opnd_frac, out_reg, multiplier_quotient_reg;
   logic [11:0]        acc_exp, opnd_exp, operand_exponent_hold, shift_count, e;
   int                 errors = 0;
   int                 cmp_count = 0;
   int                 cycles = 0;
   int                 seed = 24664;
   int                 r;

   fmd_datapath fmd_datapath_i (.clk, .rst_b, .start, .op, .extended_precision_mode,
      .floating_accumulator, .acc_exp, .opnd_frac, .opnd_exp, .spec_valid, .spec_kind,
      .spec_cond, .out_reg, .multiplier_quotient_reg, .operand_exponent_hold,
      .shift_count, .busy, .done, .fixable, .fetch_done, .enter_process);
   fmd_seq_model fmd_seq_model_i (.clk, .busy, .done, .start, .op, .extended_precision_mode,
      .floating_accumulator, .acc_exp, .opnd_frac, .opnd_exp, .spec_valid, .spec_kind,
      .spec_cond);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic conclude;
      $display("Compares %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("[ERR] %0t run stalled", $time);
         conclude();
      end
   end

   task automatic check(input logic [71:0] seen, input logic [71:0] want, input string what);
      cmp_count++;
      if (seen !== want) begin
         errors++;
         $display("[ERR] %0t %s: seen %h want %h", $time, what, seen, want);
      end
   endtask

   function automatic logic [59:0] rfrac();
      logic [59:0] m;
      m = {2'b01, 22'($random(seed)), 36'h0};
      return $random(seed) & 1 ? -m : m;
   endfunction

   // Returns {exponent, fraction}; low 36 bits masked in 24-bit mode
   function automatic logic [71:0] model(fmd_pkg::fmd_op_t o, logic [59:0] f, logic [11:0] fe,
                                         logic [59:0] g, logic [11:0] ge, logic x);
      logic [59:0] a, b, q, m;
      logic [11:0] re;
      a = f[59] ? -f : f;
      b = g[59] ? -g : g;
      m = x ? {60{1'b1}} : 60'hffffff000000000;
      q = f;
      re = fe;
      case (o)
         fmd_pkg::FMD_OP_MUL: begin
            // Shift-and-add leaves the product at half scale; normalize absorbs it
            q = (a >> 36) * (b >> 36) << 12;
            re = ge;
         end
         fmd_pkg::FMD_OP_DIV: begin
            q = {a[59:36], 27'h0} / (b >> 36);
            re = ge;
            if (q[27]) begin
               q = q >> 1;
               re = ge + 12'h001;
            end
            q = q << 32;
         end
         fmd_pkg::FMD_OP_FIX: begin
            if ($signed(fe) <= 12'sd23) begin
               q = $signed(f) >>> (12'sd23 - $signed(fe));
               re = 12'h017;
            end
            return {re, q & m};
         end
         fmd_pkg::FMD_OP_FLOAT: re = 12'h017;
         default: ;
      endcase
      if (o <= fmd_pkg::FMD_OP_DIV && (f[59] ^ g[59])) q = -q;
      while (q != 0 && q[59] == q[58] && q != 60'hc00000000000000) begin
         q = q << 1;
         re = re - 12'h001;
      end
      return {re, q & m};
   endfunction

   task automatic run(fmd_pkg::fmd_op_t o, logic x, logic [59:0] f, logic [11:0] fe,
                      logic [59:0] g, logic [11:0] ge);
      logic seen, bz;
      logic [59:0] gm;
      fmd_seq_model_i.issue(o, x, f, fe, g, ge, seen, bz);
      gm = g[59] ? -g : g;
      check(seen, 1'b1, "done pulse");
      check(bz, 1'b1, "busy after start");
      check({operand_exponent_hold, out_reg}, model(o, f, fe, g, ge, x), "result");
      check(fixable, $signed(fe) <= 12'sd23, "fixable flag");
      if (o == fmd_pkg::FMD_OP_FIX && $signed(fe) <= 12'sd23)
         check(shift_count, 12'h000, "fix count");
      if (o == fmd_pkg::FMD_OP_MUL && !x)
         check(multiplier_quotient_reg, gm >> 24, "multiplier shifted out");
      $display("Test op %0d done", o);
   endtask

   initial begin
      rst_b = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      rst_b = 1'b1;
      check({busy, done, fetch_done, enter_process, out_reg}, 72'h0, "reset state");
      for (int k = 0; k < 6; k++) begin
         for (int c = 0; c < 2; c++) begin
            fmd_seq_model_i.spec(fmd_pkg::fmd_spec_t'(k), c[0], !(k == 5 && c == 1));
            check({fetch_done, enter_process}, (k < 4 || (k == 4 && c == 0)) ? 2'b10 : 2'b01,
                  "special class");
         end
      end
      $display("Test special classes done");
      run(fmd_pkg::FMD_OP_FLOAT, 1'b0, 60'h000001000000000, 12'h000, 60'h0, 12'h000);
      run(fmd_pkg::FMD_OP_FLOAT, 1'b1, 60'h000000000000001, 12'h000, 60'h0, 12'h000);
      run(fmd_pkg::FMD_OP_FIX, 1'b0, 60'h700000000000000, 12'h003, 60'h0, 12'h000);
      run(fmd_pkg::FMD_OP_FIX, 1'b0, 60'h400000000000000, 12'h018, 60'h0, 12'h000);
      run(fmd_pkg::FMD_OP_NORM, 1'b0, 60'hf40000000000000, 12'h002, 60'h0, 12'h000);
      run(fmd_pkg::FMD_OP_NORM, 1'b0, 60'hc00000000000000, 12'h005, 60'h0, 12'h000);
      run(fmd_pkg::FMD_OP_MUL, 1'b0, 60'h400000000000000, 12'h000,
          60'h400000000000000, 12'h005);
      run(fmd_pkg::FMD_OP_MUL, 1'b0, 60'ha00000000000000, 12'h000,
          60'h500000000000000, 12'h002);
      run(fmd_pkg::FMD_OP_DIV, 1'b0, 60'h600000000000000, 12'h000,
          60'h400000000000000, 12'h003);
      run(fmd_pkg::FMD_OP_DIV, 1'b0, 60'hc00000000000000, 12'h000,
          60'h600000000000000, 12'h001);
      repeat (30) begin
         r = $unsigned($random(seed)) % 5;
         e = 12'($unsigned($random(seed)) % 32) - 12'h004;
         run(fmd_pkg::fmd_op_t'(r), 1'b0, rfrac(), e, rfrac(), e + 12'h003);
      end
      conclude();
   end
endmodule

// ---- src/fmd_datapath.sv ----
// Multiply, divide, float, fix and normalize datapath for mantissa fractions
`timescale 1ns/1ps
// What this block does
// [RL1] Second multiply pulse shifts the multiplier right to the next tested bit.
// [RL2] Finished product moves from shift register to output; operand exponent is held.
// [RL3] Divide works on magnitudes and negates quotient when signs differ.
// [RL4] Divide loads accumulator fraction into first operand, operand magnitude to shifter.
// [RL5] A divide cycle is two clocks; first subtracts divisor from remainder.
// [RL6] Carry out one: difference to output register, quotient gets a one.
// [RL7] Then remainder doubled into first operand and output shifted left, equal.
// [RL8] Carry out zero: quotient gets zero, output doubles, then copied to first operand.
// [RL9] Finished quotient moves to output register; operand exponent is held.
// [RL10] Divide mini state 3 halves quotient and sets counter one if first was positive.
// [RL11] Exit, clear, start-floating, start-double finish inside fetch state 0.
// [RL12] False conditional jump stays in fetch; other specials enter process state.
// [RL13] Mantissas are two's-complement fractions, 24 bits or 60 in extended mode.
// [RL14] Float loads exponent octal 27 then normalizes, one exponent step per shift.
// [RL15] Fix sets exponent octal 27, counts the difference down, shifting right.
// [RL16] Exponent above octal 27 is not fixable; the fixable flag reports it.
// [RL17] Normalize shifts left until bits 0 and 1 differ, only they are set, or the fraction is zero.
// [RL18] Each normalize shift is counted; the count is then added to the exponent.
// [RL19] First multiply pulse loads sum into output register when the tested multiplier bit is one, else the partial product, and decrements counter.
// [RL20] Multiply uses magnitudes and negates the product when signs differ.
// [RL21] Every arithmetic operation except fix ends with normalization.
module fmd_datapath (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                start,
   input  wire fmd_pkg::fmd_op_t    op,
   input  wire logic                extended_precision_mode,
   input  wire logic [59:0]         floating_accumulator,
   input  wire logic [11:0]         acc_exp,
   input  wire logic [59:0]         opnd_frac,
   input  wire logic [11:0]         opnd_exp,
   input  wire logic                spec_valid,
   input  wire fmd_pkg::fmd_spec_t  spec_kind,
   input  wire logic                spec_cond,
   output logic [59:0]              out_reg,
   output logic [59:0]              multiplier_quotient_reg,
   output logic [11:0]              operand_exponent_hold,
   output logic [11:0]              shift_count,
   output logic                     busy,
   output logic                     done,
   output logic                     fixable,
   output logic                     fetch_done,
   output logic                     enter_process
);
   // Bit 0 of the fraction (sign) is vector bit 59
   function automatic logic [59:0] abs_frac(input logic [59:0] v);
      return v[59] ? 60'(-v) : v;
   endfunction

   function automatic logic [59:0] mode_mask(input logic ext);
      return ext ? {60{1'b1}} : {{24{1'b1}}, 36'h0};
   endfunction

   function automatic logic over_fix(input logic [11:0] e);
      return $signed(e) > $signed(fmd_pkg::EXP_FIX);
   endfunction

   function automatic logic norm_stop(input logic [59:0] v);
      return (v[59] != v[58]) || (v == {2'b11, 58'h0}) || (v == 60'h0);
   endfunction

   fmd_pkg::fmd_state_t state;
   fmd_pkg::fmd_state_t next_state;
   fmd_pkg::fmd_op_t    op_q;
   logic [59:0]         a_reg;
   logic [59:0]         b_reg;
   logic                ext_q;
   logic                neg_q;
   logic                first_pos;
   logic                first_cycle;
   logic [60:0]         trial;
   logic                carry_out;
   logic [59:0]         mul_sum;
   logic                mul_bit;
   logic                stop_now;
   logic [59:0]         result_src;
   logic [59:0]         start_mask;

   fmd_spec_if sp ();
   fmd_spec_class u_class (
      .sp (sp)
   );
   assign sp.kind      = spec_kind;
   assign sp.cond_true = spec_cond;

   assign start_mask = mode_mask(extended_precision_mode);
   assign trial      = {1'b0, a_reg} - {1'b0, b_reg}; // RL5
   assign carry_out  = ~trial[60];
   assign mul_bit    = ext_q ? multiplier_quotient_reg[fmd_pkg::TEST_BIT_EXT]
                             : multiplier_quotient_reg[fmd_pkg::TEST_BIT_NORM];
   assign mul_sum    = a_reg + b_reg;
   assign stop_now   = norm_stop(out_reg);
   assign result_src = (op_q == fmd_pkg::FMD_OP_DIV) ? multiplier_quotient_reg : b_reg;

   always_comb begin
      next_state = state;
      unique case (state)
         fmd_pkg::FMD_S_IDLE: begin
            if (start) begin
               unique case (op)
                  fmd_pkg::FMD_OP_MUL: next_state = fmd_pkg::FMD_S_MUL_A;
                  fmd_pkg::FMD_OP_DIV: next_state = fmd_pkg::FMD_S_DIV_A;
                  fmd_pkg::FMD_OP_FIX: begin
                     if (over_fix(acc_exp)) begin
                        next_state = fmd_pkg::FMD_S_EXP; // RL16
                     end else begin
                        next_state = fmd_pkg::FMD_S_FIX;
                     end
                  end
                  default: next_state = fmd_pkg::FMD_S_NORM;
               endcase
            end
         end
         fmd_pkg::FMD_S_MUL_A: next_state = fmd_pkg::FMD_S_MUL_B;
         fmd_pkg::FMD_S_MUL_B: begin
            next_state = (shift_count == 12'h000) ? fmd_pkg::FMD_S_STORE
                                                  : fmd_pkg::FMD_S_MUL_A;
         end
         fmd_pkg::FMD_S_DIV_A: next_state = fmd_pkg::FMD_S_DIV_B;
         fmd_pkg::FMD_S_DIV_B: begin
            next_state = (shift_count == 12'h000) ? fmd_pkg::FMD_S_DIV_3
                                                  : fmd_pkg::FMD_S_DIV_A;
         end
         fmd_pkg::FMD_S_DIV_3: next_state = fmd_pkg::FMD_S_STORE;
         fmd_pkg::FMD_S_STORE: next_state = fmd_pkg::FMD_S_NORM; // RL21
         fmd_pkg::FMD_S_FIX: begin
            if (shift_count == 12'h000) begin
               next_state = fmd_pkg::FMD_S_EXP;
            end
         end
         fmd_pkg::FMD_S_NORM: begin
            if (stop_now) begin
               next_state = fmd_pkg::FMD_S_EXP;
            end
         end
         fmd_pkg::FMD_S_EXP: next_state = fmd_pkg::FMD_S_IDLE;
         default: next_state = fmd_pkg::FMD_S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= fmd_pkg::FMD_S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Operation, mode and sign captured once so operand fractions may change after start
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         op_q  <= fmd_pkg::FMD_OP_MUL;
         ext_q <= 1'b0;
         neg_q <= 1'b0;
      end else if (state == fmd_pkg::FMD_S_IDLE && start) begin
         op_q  <= op;
         ext_q <= extended_precision_mode;
         neg_q <= floating_accumulator[59] ^ opnd_frac[59]; // RL3 RL20
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         a_reg <= 60'h0;
      end else if (state == fmd_pkg::FMD_S_IDLE && start) begin
         a_reg <= abs_frac(floating_accumulator & start_mask); // RL4 RL20
      end else if (state == fmd_pkg::FMD_S_DIV_B) begin
         a_reg <= first_cycle ? out_reg << 1 : out_reg; // RL7 RL8
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         b_reg <= 60'h0;
      end else if (state == fmd_pkg::FMD_S_IDLE && start) begin
         // Product accumulates from zero; divisor magnitude sits here
         b_reg <= (op == fmd_pkg::FMD_OP_DIV) ? abs_frac(opnd_frac & start_mask) : 60'h0; // RL4
      end else if (state == fmd_pkg::FMD_S_MUL_B) begin
         b_reg <= out_reg >> 1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         out_reg <= 60'h0;
      end else begin
         unique case (state)
            fmd_pkg::FMD_S_IDLE: begin
               if (start) begin
                  // Divide doubles this copy, so it must start as the remainder magnitude
                  out_reg <= (op == fmd_pkg::FMD_OP_DIV) ?
                             abs_frac(floating_accumulator & start_mask) :
                             floating_accumulator & start_mask; // RL13 RL4 RL8
               end
            end
            fmd_pkg::FMD_S_MUL_A: out_reg <= mul_bit ? mul_sum : b_reg; // RL19
            fmd_pkg::FMD_S_DIV_A: begin
               out_reg <= carry_out ? trial[59:0] : out_reg << 1; // RL6 RL8
            end
            fmd_pkg::FMD_S_DIV_B: begin
               if (first_cycle) begin
                  out_reg <= out_reg << 1; // RL7
               end
            end
            fmd_pkg::FMD_S_STORE: begin
               out_reg <= neg_q ? 60'(-result_src) : result_src; // RL2 RL9 RL3 RL20
            end
            fmd_pkg::FMD_S_FIX: begin
               if (shift_count != 12'h000) begin
                  out_reg <= 60'($signed(out_reg) >>> 1); // RL15
               end
            end
            fmd_pkg::FMD_S_NORM: begin
               if (!stop_now) begin
                  out_reg <= out_reg << 1; // RL17
               end
            end
            fmd_pkg::FMD_S_EXP: out_reg <= out_reg & mode_mask(ext_q); // RL13
            default: out_reg <= out_reg;
         endcase
      end
   end

   // Remembers which path the last trial took, for the second half
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         first_cycle <= 1'b0;
      end else if (state == fmd_pkg::FMD_S_DIV_A) begin
         first_cycle <= carry_out;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         first_pos <= 1'b0;
      end else if (state == fmd_pkg::FMD_S_IDLE && start) begin
         first_pos <= 1'b0;
      end else if (state == fmd_pkg::FMD_S_DIV_A && shift_count == (ext_q ?
                   fmd_pkg::DIV_CNT_EXT : fmd_pkg::DIV_CNT_NORM)) begin
         first_pos <= carry_out;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         multiplier_quotient_reg <= 60'h0;
      end else if (state == fmd_pkg::FMD_S_IDLE && start) begin
         multiplier_quotient_reg <= (op == fmd_pkg::FMD_OP_MUL) ?
                                    abs_frac(opnd_frac & start_mask) : 60'h0;
      end else if (state == fmd_pkg::FMD_S_MUL_B) begin
         multiplier_quotient_reg <= multiplier_quotient_reg >> 1; // RL1
      end else if (state == fmd_pkg::FMD_S_DIV_A) begin
         multiplier_quotient_reg <= (multiplier_quotient_reg << 1) |
            (60'(carry_out) << (ext_q ? fmd_pkg::QLSB_EXT : fmd_pkg::QLSB_NORM)); // RL6 RL8
      end else if (state == fmd_pkg::FMD_S_DIV_3 && first_pos) begin
         multiplier_quotient_reg <= multiplier_quotient_reg >> 1; // RL10
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shift_count <= fmd_pkg::SC_RESET;
      end else begin
         unique case (state)
            fmd_pkg::FMD_S_IDLE: begin
               if (start) begin
                  unique case (op)
                     fmd_pkg::FMD_OP_MUL: begin
                        shift_count <= extended_precision_mode ? fmd_pkg::MUL_CNT_EXT
                                                               : fmd_pkg::MUL_CNT_NORM;
                     end
                     fmd_pkg::FMD_OP_DIV: begin
                        shift_count <= extended_precision_mode ? fmd_pkg::DIV_CNT_EXT
                                                               : fmd_pkg::DIV_CNT_NORM;
                     end
                     fmd_pkg::FMD_OP_FIX: begin
                        // Unfixable numbers must leave the exponent untouched at EXP
                        shift_count <= over_fix(acc_exp) ? 12'h000
                                                         : fmd_pkg::EXP_FIX - acc_exp; // RL15 RL16
                     end
                     default: shift_count <= 12'h000;
                  endcase
               end
            end
            fmd_pkg::FMD_S_MUL_A: shift_count <= shift_count - 12'h001; // RL19
            fmd_pkg::FMD_S_DIV_A: shift_count <= shift_count - 12'h001;
            fmd_pkg::FMD_S_DIV_3: shift_count <= {11'h000, first_pos}; // RL10
            fmd_pkg::FMD_S_STORE: begin
               if (op_q == fmd_pkg::FMD_OP_MUL) begin
                  shift_count <= 12'h000;
               end
            end
            fmd_pkg::FMD_S_FIX: begin
               if (shift_count != 12'h000) begin
                  shift_count <= shift_count - 12'h001; // RL15
               end
            end
            fmd_pkg::FMD_S_NORM: begin
               if (!stop_now) begin
                  shift_count <= shift_count - 12'h001; // RL18
               end
            end
            fmd_pkg::FMD_S_EXP: shift_count <= 12'h000;
            default: shift_count <= shift_count;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         operand_exponent_hold <= fmd_pkg::EXP_RESET;
      end else if (state == fmd_pkg::FMD_S_IDLE && start) begin
         unique case (op)
            fmd_pkg::FMD_OP_FLOAT: operand_exponent_hold <= fmd_pkg::EXP_FIX; // RL14
            fmd_pkg::FMD_OP_FIX: begin
               // A number that cannot be fixed keeps its exponent
               operand_exponent_hold <= over_fix(acc_exp) ? acc_exp : fmd_pkg::EXP_FIX; // RL15
            end
            default: operand_exponent_hold <= acc_exp;
         endcase
      end else if (state == fmd_pkg::FMD_S_STORE) begin
         operand_exponent_hold <= opnd_exp; // RL2 RL9
      end else if (state == fmd_pkg::FMD_S_EXP) begin
         operand_exponent_hold <= operand_exponent_hold + shift_count; // RL18 RL14
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy          <= 1'b0;
         done          <= 1'b0;
         fixable       <= 1'b0;
         fetch_done    <= 1'b0;
         enter_process <= 1'b0;
      end else begin
         busy          <= next_state != fmd_pkg::FMD_S_IDLE;
         done          <= state == fmd_pkg::FMD_S_EXP;
         fixable       <= !over_fix(acc_exp); // RL16
         fetch_done    <= spec_valid && sp.stay_fetch; // RL11 RL12
         enter_process <= spec_valid && sp.go_process; // RL12
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_mul_cycle;
      state == fmd_pkg::FMD_S_MUL_A ##1 state == fmd_pkg::FMD_S_MUL_B;
   endsequence
   sequence s_div_pos;
      state == fmd_pkg::FMD_S_DIV_A && carry_out ##1 state == fmd_pkg::FMD_S_DIV_B;
   endsequence

   property p_mul_sc;
      state == fmd_pkg::FMD_S_MUL_A |=> shift_count == $past(shift_count) - 12'h001;
   endproperty
   a_mul_sc: assert property (p_mul_sc) else $error("multiply counter not decremented"); // RL19
   property p_mul_shift;
      s_mul_cycle |=> multiplier_quotient_reg == ($past(multiplier_quotient_reg, 2) >> 1);
   endproperty
   a_mul_shift: assert property (p_mul_shift) else $error("multiplier not shifted"); // RL1
   property p_div_one;
      state == fmd_pkg::FMD_S_DIV_A && carry_out |=> out_reg == $past(trial[59:0]);
   endproperty
   a_div_one: assert property (p_div_one) else $error("difference not kept"); // RL6
   property p_div_equal;
      s_div_pos |=> a_reg == out_reg && a_reg == ($past(out_reg) << 1);
   endproperty
   a_div_equal: assert property (p_div_equal) else $error("remainder copies differ"); // RL7
   property p_div_zero;
      state == fmd_pkg::FMD_S_DIV_A && !carry_out |=> out_reg == ($past(out_reg) << 1)
         ##1 a_reg == $past(out_reg);
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("zero path wrong"); // RL8
   property p_norm;
      state == fmd_pkg::FMD_S_NORM && !stop_now |=> out_reg == ($past(out_reg) << 1)
         && shift_count == $past(shift_count) - 12'h001;
   endproperty
   a_norm: assert property (p_norm) else $error("normalize step wrong"); // RL17 RL18
   property p_fix;
      state == fmd_pkg::FMD_S_FIX && shift_count != 12'h000 |=>
         out_reg == 60'($signed($past(out_reg)) >>> 1);
   endproperty
   a_fix: assert property (p_fix) else $error("fix shift wrong"); // RL15
   property p_store_norm;
      state == fmd_pkg::FMD_S_STORE |=> state == fmd_pkg::FMD_S_NORM
         && operand_exponent_hold == $past(opnd_exp);
   endproperty
   a_store_norm: assert property (p_store_norm) else $error("no normalize after op"); // RL21
   property p_spec_fetch;
      spec_valid && spec_kind inside {fmd_pkg::FMD_SP_EXIT, fmd_pkg::FMD_SP_CLEAR_ACC,
         fmd_pkg::FMD_SP_START_F, fmd_pkg::FMD_SP_START_D} |=> fetch_done && !enter_process;
   endproperty
   a_spec_fetch: assert property (p_spec_fetch) else $error("special left fetch"); // RL11
endmodule

// ---- src/fmd_pkg.sv ----
// Constants, enumerations and state codes for the fraction arithmetic datapath
package fmd_pkg;
   localparam int          FRAC_W        = 60;
   localparam int          EXP_W         = 12;
   localparam int          NORM_BITS     = 24;
   localparam logic [11:0] EXP_FIX       = 12'h017;
   localparam logic [11:0] MUL_CNT_NORM  = 12'h018;
   localparam logic [11:0] MUL_CNT_EXT   = 12'h03c;
   localparam logic [11:0] DIV_CNT_NORM  = 12'h01c;
   localparam logic [11:0] DIV_CNT_EXT   = 12'h03c;
   localparam int          TEST_BIT_NORM = 36;
   localparam int          TEST_BIT_EXT  = 0;
   localparam int          QLSB_NORM     = 32;
   localparam int          QLSB_EXT      = 0;
   localparam logic [11:0] SC_RESET      = 12'h000;
   localparam logic [11:0] EXP_RESET     = 12'h000;

   typedef enum logic [2:0] {
      FMD_OP_MUL   = 3'h0,
      FMD_OP_DIV   = 3'h1,
      FMD_OP_FLOAT = 3'h2,
      FMD_OP_FIX   = 3'h3,
      FMD_OP_NORM  = 3'h4
   } fmd_op_t;

   typedef enum logic [2:0] {
      FMD_SP_EXIT       = 3'h0,
      FMD_SP_CLEAR_ACC  = 3'h1,
      FMD_SP_START_F    = 3'h2,
      FMD_SP_START_D    = 3'h3,
      FMD_SP_COND_JUMP  = 3'h4,
      FMD_SP_OTHER      = 3'h5
   } fmd_spec_t;

   typedef enum logic [9:0] {
      FMD_S_IDLE  = 10'h001,
      FMD_S_MUL_A = 10'h002,
      FMD_S_MUL_B = 10'h004,
      FMD_S_DIV_A = 10'h008,
      FMD_S_DIV_B = 10'h010,
      FMD_S_DIV_3 = 10'h020,
      FMD_S_STORE = 10'h040,
      FMD_S_FIX   = 10'h080,
      FMD_S_NORM  = 10'h100,
      FMD_S_EXP   = 10'h200
   } fmd_state_t;
endpackage

// ---- src/fmd_spec_class.sv ----
// Decides where a special-format instruction finishes in the fetch sequence
`timescale 1ns/1ps
module fmd_spec_class (
   fmd_spec_if.cls sp
);
   always_comb begin
      unique case (sp.kind)
         fmd_pkg::FMD_SP_EXIT, fmd_pkg::FMD_SP_CLEAR_ACC,
         fmd_pkg::FMD_SP_START_F, fmd_pkg::FMD_SP_START_D: begin
            sp.stay_fetch = 1'b1; // RL11
            sp.go_process = 1'b0;
         end
         fmd_pkg::FMD_SP_COND_JUMP: begin
            sp.stay_fetch = ~sp.cond_true; // RL12
            sp.go_process = sp.cond_true;
         end
         default: begin
            sp.stay_fetch = 1'b0;
            sp.go_process = 1'b1; // RL12
         end
      endcase
   end
endmodule

// ---- src/fmd_spec_if.sv ----
// Carrier between the datapath and its special-instruction classifier
`timescale 1ns/1ps
interface fmd_spec_if;
   fmd_pkg::fmd_spec_t kind;
   logic               cond_true;
   logic               stay_fetch;
   logic               go_process;
   modport top (output kind, output cond_true, input stay_fetch, input go_process);
   modport cls (input kind, input cond_true, output stay_fetch, output go_process);
endinterface
